//--- core/vp_pkg.sv
// Purpose: shared constants and types for the voltage protection block
// Assumes: per-unit settings in thousandths, delays in 10 ms steps
// Notes: unit index order is fixed by UNIT_* constants below
package vp_pkg;

	// ---------------------------------------------------------------
	// units
	// ---------------------------------------------------------------
	localparam int NUM_UNITS = 6;
	localparam int UNIT_PH_UV = 0;
	localparam int UNIT_PH_OV = 1;
	localparam int UNIT_ZS_OV = 2;
	localparam int UNIT_NS_OV = 3;
	localparam int UNIT_AUX_UV = 4;
	localparam int UNIT_AUX_OV = 5;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_KHZ = 125000;
	localparam int STEP_MS = 10;
	localparam int STEP_CYCLES = CLK_KHZ * STEP_MS;
	localparam logic [15:0] DELAY_MAX = 16'hea60;
	localparam logic [15:0] NS_PU_MAX = 16'h04e2;
	localparam logic [31:0] PU_SCALE = 32'h000003e8;

	// ---------------------------------------------------------------
	// register map
	// ---------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] UNIT_STRIDE = 8'h10;
	localparam logic [1:0] W_CFG = 2'h0;
	localparam logic [1:0] W_PICKUP = 2'h1;
	localparam logic [1:0] W_DELAY = 2'h2;
	localparam logic [1:0] W_AUXSET = 2'h3;
	localparam logic [7:0] OFF_PH_NOM = 8'h60;
	localparam logic [7:0] OFF_AUX_NOM = 8'h64;
	localparam logic [7:0] OFF_VT_CFG = 8'h68;
	localparam logic [7:0] OFF_STATUS = 8'h6c;
	localparam int CFG_EN = 0;
	localparam int CFG_INV = 1;
	localparam int CFG_TGT_LO = 2;
	localparam int VT_DELTA = 0;
	localparam int VT_UV_PP = 1;
	localparam int ST_PKP = 0;
	localparam int ST_OP = 8;
	localparam int ST_TGT = 16;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [5:0][15:0] PU_RST = {16'h044c, 16'h02bc, 16'h012c, 16'h012c, 16'h044c, 16'h02bc};
	localparam logic [5:0][15:0] DLY_RST = {16'h0064, 16'h0064, 16'h0032, 16'h0064, 16'h0064, 16'h0064};
	localparam logic [5:0][15:0] AUXSET_RST = {16'h0000, 16'h00c8, 16'h0032, 16'h0000, 16'h0000, 16'h00c8};
	localparam logic [15:0] NOM_RST = 16'h0064;

	typedef enum logic [1:0] {VP_TGT_SELF, VP_TGT_LATCH, VP_TGT_OFF} vp_tgt_t;

	// ---------------------------------------------------------------
	// carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [2:0][15:0] pg_re;
		logic [2:0][15:0] pg_im;
		logic [2:0][15:0] pp_mag;
		logic [15:0] neg_mag;
		logic [15:0] aux_mag;
	} vp_meas_t;

	typedef struct packed {
		logic [47:0] acc;
		logic [15:0] rst;
		logic pkp;
		logic op;
		logic tgt;
	} vp_elem_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic [31:0] step_cnt;
		logic step;
		logic [5:0][3:0] cfg;
		logic [5:0][15:0] pu;
		logic [5:0][15:0] dly;
		logic [5:0][15:0] auxset;
		logic [15:0] ph_nom;
		logic [15:0] aux_nom;
		logic [1:0] vt_cfg;
		logic [5:0] tgt_clr;
		logic [5:0] pickup;
		logic [5:0] operate;
		logic [5:0] target;
		vp_elem_t [5:0] elem;
	} vp_state_t;

endpackage

//--- core/vp_voltage_protection.sv
// Purpose: six voltage protection units with APB settings and status
// Assumes: measurements and block operands come from logic on pclk
// Notes: magnitudes of phasors use a max plus 3/8 min approximation
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - phase under unit drops instantly above dropout
// - delay sets shortest phase under operate time
// - below minimum voltage inhibits; zero disables inhibit
// - phase under uses ground or line voltage
// - phase over uses line voltage, measured or computed
// - phase over instant or definite time delay
// - zero seq unit compares three times V0
// - zero seq pickup based on phase nominal
// - negative seq pickup thousandths, default 0.300
// - negative seq delays to 600 s, default 0.5
// - aux under timer starts below pickup
// - aux pickups based on aux nominal
// - aux under definite or inverse, same equations
// - aux under resets instantly, inhibited below minimum
// - aux over detects aux voltage above pickup
// - inverse time is delay over (1 - V/pickup)
// - definite time delay to 600 s in 10 ms
module vp_voltage_protection #(
	parameter int TICK_CYCLES = vp_pkg::STEP_CYCLES
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [vp_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// measurement front end and block operands
	input wire vp_pkg::vp_meas_t meas,
	input wire logic [5:0] block,
	// unit outputs
	output logic [5:0] pickup,
	output logic [5:0] operate,
	output logic [5:0] target
);
	import vp_pkg::*;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [20:0] mag(input logic signed [19:0] re, input logic signed [19:0] im);
		logic [20:0] ar;
		logic [20:0] ai;
		logic [20:0] big;
		logic [20:0] sml;
		ar = re[19] ? (21'd0 - {re[19], re}) : {1'b0, re};
		ai = im[19] ? (21'd0 - {im[19], im}) : {1'b0, im};
		big = (ar > ai) ? ar : ai;
		sml = (ar > ai) ? ai : ar;
		return big + (sml >> 2) + (sml >> 3);
	endfunction

	function automatic logic signed [19:0] sx(input logic [15:0] v);
		return {{4{v[15]}}, v};
	endfunction

	function automatic logic [20:0] min3(input logic [20:0] a, input logic [20:0] b, input logic [20:0] c);
		logic [20:0] m;
		m = (a < b) ? a : b;
		return (m < c) ? m : c;
	endfunction

	function automatic logic [20:0] max3(input logic [20:0] a, input logic [20:0] b, input logic [20:0] c);
		logic [20:0] m;
		m = (a > b) ? a : b;
		return (m > c) ? m : c;
	endfunction

	// measured value and per-unit setting on one scale
	function automatic logic [31:0] scale_v(input logic [20:0] v);
		return 32'(v) * PU_SCALE;
	endfunction

	function automatic logic [31:0] scale_pu(input logic [15:0] pu, input logic [15:0] nom);
		return 32'(pu) * 32'(nom);
	endfunction

	function automatic logic [15:0] sat(input logic [15:0] v, input logic [15:0] lim);
		return (v > lim) ? lim : v;
	endfunction

	// one timing step of a unit
	function automatic vp_elem_t step_elem(
		input vp_elem_t e,
		input logic run,
		input logic under,
		input logic inv,
		input logic [31:0] v,
		input logic [31:0] pk,
		input logic [15:0] dly,
		input logic [15:0] rdly,
		input logic tick,
		input logic [1:0] tmode,
		input logic tclr
	);
		vp_elem_t n;
		logic cond;
		logic [47:0] inc;
		logic [47:0] thr;
		logic [47:0] lim;
		n = e;
		cond = under ? (v < pk) : (v > pk);
		// inverse: integrate (pk - v) until it reaches dly * pk
		inc = (inv && under) ? 48'(pk - v) : 48'd1;
		thr = (inv && under) ? 48'(dly) * 48'(pk) : 48'(dly);
		// one step beyond the threshold: the first step after pickup is partial
		lim = thr + inc;
		if (!run) begin
			n.acc = '0;
			n.rst = '0;
			n.pkp = 1'b0;
			n.op = 1'b0;
		end else if (cond) begin
			n.pkp = 1'b1;
			n.rst = '0;
			if (tick && e.acc < lim) begin
				n.acc = e.acc + inc;
			end
			// zero delay operates at once
			n.op = e.op | (dly == 16'd0) | (n.acc >= lim);
		end else begin
			n.pkp = 1'b0;
			n.acc = '0;
			if (e.op && e.rst < rdly) begin
				n.op = 1'b1;
				if (tick) begin
					n.rst = e.rst + 16'd1;
				end
			end else begin
				n.op = 1'b0;
				n.rst = '0;
			end
		end
		unique case (tmode)
			VP_TGT_SELF: n.tgt = n.op;
			VP_TGT_LATCH: n.tgt = n.op | (e.tgt & ~tclr);
			default: n.tgt = 1'b0;
		endcase
		return n;
	endfunction

	// ---------------------------------------------------------------
	// measurements
	// ---------------------------------------------------------------
	logic [2:0][20:0] pg_m;
	logic [2:0][20:0] ppc_m;
	logic [2:0][20:0] ppd_m;
	logic [20:0] v0x3;
	logic [5:0][31:0] v_s;
	logic [5:0][31:0] pk_s;
	logic [5:0] inhib;
	logic [5:0] under;
	vp_state_t s_reg;
	vp_state_t s_next;

	always_comb begin
		for (int p = 0; p < 3; p++) begin
			pg_m[p] = mag(sx(meas.pg_re[p]), sx(meas.pg_im[p]));
			// line voltage from star phasors: a-b, b-c, c-a
			ppc_m[p] = mag(sx(meas.pg_re[p]) - sx(meas.pg_re[(p + 1) % 3]),
				sx(meas.pg_im[p]) - sx(meas.pg_im[(p + 1) % 3]));
			ppd_m[p] = {5'd0, meas.pp_mag[p]};
		end
		// residual sum of the three phasors is 3V0
		v0x3 = mag(sx(meas.pg_re[0]) + sx(meas.pg_re[1]) + sx(meas.pg_re[2]),
			sx(meas.pg_im[0]) + sx(meas.pg_im[1]) + sx(meas.pg_im[2]));
		// delta transformers give no ground voltage
		if (s_reg.vt_cfg[VT_DELTA] || s_reg.vt_cfg[VT_UV_PP]) begin
			v_s[UNIT_PH_UV] = scale_v(min3(ppd_m[0], ppd_m[1], ppd_m[2]));
		end else begin
			v_s[UNIT_PH_UV] = scale_v(min3(pg_m[0], pg_m[1], pg_m[2]));
		end
		if (s_reg.vt_cfg[VT_DELTA]) begin
			v_s[UNIT_PH_OV] = scale_v(max3(ppd_m[0], ppd_m[1], ppd_m[2]));
		end else begin
			v_s[UNIT_PH_OV] = scale_v(max3(ppc_m[0], ppc_m[1], ppc_m[2]));
		end
		v_s[UNIT_ZS_OV] = scale_v(v0x3);
		v_s[UNIT_NS_OV] = scale_v({5'd0, meas.neg_mag});
		v_s[UNIT_AUX_UV] = scale_v({5'd0, meas.aux_mag});
		v_s[UNIT_AUX_OV] = scale_v({5'd0, meas.aux_mag});
		for (int u = 0; u < NUM_UNITS; u++) begin
			if (u >= UNIT_AUX_UV) begin
				pk_s[u] = scale_pu(s_reg.pu[u], s_reg.aux_nom);
			end else begin
				pk_s[u] = scale_pu(s_reg.pu[u], s_reg.ph_nom);
			end
			under[u] = (u == UNIT_PH_UV) || (u == UNIT_AUX_UV);
			inhib[u] = 1'b0;
		end
		// minimum of zero never inhibits, so a dead source trips
		inhib[UNIT_PH_UV] = v_s[UNIT_PH_UV] < scale_pu(s_reg.auxset[UNIT_PH_UV], s_reg.ph_nom);
		inhib[UNIT_AUX_UV] = v_s[UNIT_AUX_UV] < scale_pu(s_reg.auxset[UNIT_AUX_UV], s_reg.aux_nom);
		// residual voltage is meaningless without star transformers
		inhib[UNIT_ZS_OV] = s_reg.vt_cfg[VT_DELTA];
	end

	// ---------------------------------------------------------------
	// next state: bus, settings, units
	// ---------------------------------------------------------------
	always_comb begin
		logic [1:0] wsel;
		logic [2:0] usel;
		logic hit;
		logic [31:0] rd;
		logic do_wr;
		logic [15:0] dmax;
		wsel = paddr[3:2];
		usel = paddr[6:4];
		hit = 1'b0;
		rd = '0;
		dmax = DELAY_MAX;
		do_wr = 1'b0;
		s_next = s_reg;
		s_next.tgt_clr = '0;

		// 10 ms timing step
		if (s_reg.step_cnt >= 32'(TICK_CYCLES - 1)) begin
			s_next.step_cnt = '0;
			s_next.step = 1'b1;
		end else begin
			s_next.step_cnt = s_reg.step_cnt + 32'd1;
			s_next.step = 1'b0;
		end

		// read decode
		if (paddr[1:0] == 2'b00 && paddr[7] == 1'b0 && usel < 3'(NUM_UNITS)) begin
			hit = 1'b1;
			unique case (wsel)
				W_CFG: rd = {28'd0, s_reg.cfg[usel]};
				W_PICKUP: rd = {16'd0, s_reg.pu[usel]};
				W_DELAY: rd = {16'd0, s_reg.dly[usel]};
				W_AUXSET: rd = {16'd0, s_reg.auxset[usel]};
			endcase
		end else if (paddr == OFF_PH_NOM) begin
			hit = 1'b1;
			rd = {16'd0, s_reg.ph_nom};
		end else if (paddr == OFF_AUX_NOM) begin
			hit = 1'b1;
			rd = {16'd0, s_reg.aux_nom};
		end else if (paddr == OFF_VT_CFG) begin
			hit = 1'b1;
			rd = {30'd0, s_reg.vt_cfg};
		end else if (paddr == OFF_STATUS) begin
			hit = 1'b1;
			rd[ST_PKP +: 6] = s_reg.pickup;
			rd[ST_OP +: 6] = s_reg.operate;
			rd[ST_TGT +: 6] = s_reg.target;
		end

		// one wait state: ready rises in the second access cycle
		do_wr = psel && penable && s_reg.pready && pwrite && hit;
		if (psel && penable && !s_reg.pready) begin
			s_next.pready = 1'b1;
			s_next.pslverr = !hit;
			s_next.prdata = (hit && !pwrite) ? rd : 32'd0;
		end else begin
			s_next.pready = 1'b0;
			s_next.pslverr = 1'b0;
			s_next.prdata = '0;
		end

		if (do_wr) begin
			if (paddr < OFF_PH_NOM) begin
				unique case (wsel)
					W_CFG: s_next.cfg[usel] = pwdata[3:0];
					W_PICKUP: begin
						if (usel == 3'(UNIT_NS_OV)) begin
							s_next.pu[usel] = sat(pwdata[15:0], NS_PU_MAX);
						end else begin
							s_next.pu[usel] = pwdata[15:0];
						end
					end
					W_DELAY: s_next.dly[usel] = sat(pwdata[15:0], dmax);
					W_AUXSET: begin
						if (usel == 3'(UNIT_PH_UV) || usel == 3'(UNIT_AUX_UV)) begin
							s_next.auxset[usel] = pwdata[15:0];
						end else begin
							s_next.auxset[usel] = sat(pwdata[15:0], dmax);
						end
					end
				endcase
			end else if (paddr == OFF_PH_NOM) begin
				s_next.ph_nom = pwdata[15:0];
			end else if (paddr == OFF_AUX_NOM) begin
				s_next.aux_nom = pwdata[15:0];
			end else if (paddr == OFF_VT_CFG) begin
				s_next.vt_cfg = pwdata[1:0];
			end else begin
				s_next.tgt_clr = pwdata[ST_TGT +: 6];
			end
		end

		// units; a clear meeting a new operate loses
		for (int u = 0; u < NUM_UNITS; u++) begin
			s_next.elem[u] = step_elem(s_reg.elem[u],
				s_reg.cfg[u][CFG_EN] && !block[u] && !inhib[u],
				under[u],
				s_reg.cfg[u][CFG_INV],
				v_s[u], pk_s[u], s_reg.dly[u],
				under[u] ? 16'd0 : s_reg.auxset[u],
				s_reg.step,
				s_reg.cfg[u][CFG_TGT_LO +: 2],
				s_reg.tgt_clr[u]);
			s_next.pickup[u] = s_next.elem[u].pkp;
			s_next.operate[u] = s_next.elem[u].op;
			s_next.target[u] = s_next.elem[u].tgt;
		end
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '0;
			s_reg.pu <= PU_RST;
			s_reg.dly <= DLY_RST;
			s_reg.auxset <= AUXSET_RST;
			s_reg.ph_nom <= NOM_RST;
			s_reg.aux_nom <= NOM_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	assign prdata = s_reg.prdata;
	assign pready = s_reg.pready;
	assign pslverr = s_reg.pslverr;
	assign pickup = s_reg.pickup;
	assign operate = s_reg.operate;
	assign target = s_reg.target;

endmodule

`default_nettype wire

//--- test/vp_voltage_protection_sva.sv
// Purpose: port-level checks for the voltage protection block
// Assumes: sees only the top-level ports
// Notes: unit settings are invisible here, so unit checks stay mode-free
`timescale 1ns/1ps
`default_nettype none
module vp_voltage_protection_sva (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// units
	input wire logic [5:0] block,
	input wire logic [5:0] pickup,
	input wire logic [5:0] operate,
	input wire logic [5:0] target
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence acc_wait_s;
		psel && penable && !pready;
	endsequence
	sequence acc_done_s;
		psel && penable && pready;
	endsequence
	ready_one_wait_a: assert property (acc_wait_s |=> acc_done_s) else $error("no answer after one wait state");
	ready_pulse_a: assert property (pready |=> !pready) else $error("ready held too long");
	ready_access_a: assert property (pready |-> $past(psel && penable)) else $error("ready outside access");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("read data outside answer");
	err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
	misalign_err_a: assert property (acc_done_s and paddr[1:0] != 2'h0 |-> pslverr) else $error("misaligned access accepted");
	block_clear_a: assert property (|block |=> ((pickup | operate) & $past(block)) == 6'h0) else $error("blocked unit active");
	uv_op_pickup_a: assert property ((operate & ~pickup & 6'h11) == 6'h0) else $error("under unit operate without pickup");
	target_cause_a: assert property ((target & ~$past(target) & ~operate) == 6'h0) else $error("target set without operate");
endmodule
bind vp_voltage_protection vp_voltage_protection_sva vp_voltage_protection_sva_i (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.block(block), .pickup(pickup), .operate(operate), .target(target));
`default_nettype wire

//--- test/vp_meas_model.sv
// Purpose: measurement front end model feeding magnitudes
// Assumes: phases in phase with each other, imaginary parts zero
// Notes: symmetric phases give zero line voltage in star mode
`timescale 1ns/1ps
`default_nettype none
module vp_meas_model (
	// levels from the bench
	input wire logic [15:0] phase_v,
	input wire logic [15:0] line_v,
	input wire logic [15:0] neg_v,
	input wire logic [15:0] aux_v,
	// to the block
	output vp_pkg::vp_meas_t meas
);
	import vp_pkg::*;
	// star-connected source; delta only where bench sets it
	always_comb begin
		for (int p = 0; p < 3; p++) begin
			meas.pg_re[p] = phase_v;
			meas.pg_im[p] = 16'h0000;
			meas.pp_mag[p] = line_v;
		end
		meas.neg_mag = neg_v;
		meas.aux_mag = aux_v;
	end
endmodule
`default_nettype wire

//--- test/vp_voltage_protection_tb.sv
// Purpose: register and unit scenarios for the voltage protection block
// Assumes: nominals 100, so 1000 thousandths pu equals a level of 100
// Notes: step period shortened to T cycles
`timescale 1ns/1ps
`default_nettype none
module vp_voltage_protection_tb;
	import vp_pkg::*;
	localparam int T = 10;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [5:0] block, pickup, operate, target;
	logic [15:0] phase_v, line_v, neg_v, aux_v;
	vp_meas_t meas;
	int n_errors, checks_done, wcnt;
	vp_voltage_protection #(.TICK_CYCLES(T)) vp_voltage_protection_i (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .meas(meas), .block(block), .pickup(pickup),
		.operate(operate), .target(target));
	vp_meas_model vp_meas_model_i (.phase_v(phase_v), .line_v(line_v), .neg_v(neg_v), .aux_v(aux_v), .meas(meas));
	initial begin
		pclk = 0;
		forever #4 pclk = ~pclk;
	end
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task final_report();
		$display("errors %0d checks %0d", n_errors, checks_done);
		if (n_errors == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// one transfer; request held until pready is sampled high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		// no cycle count assumed; only the watchdog ends a hung wait
		do @(posedge pclk); while (pready !== 1'b1);
		r = pslverr ? 32'hffffffff : prdata;
		psel <= 0;
		penable <= 0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1, a, d);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] exp);
		apb(0, a, 32'h0);
		check(r, exp);
	endtask
	task wait_op(input int u, input logic v, input int lim);
		wcnt = 0;
		while (operate[u] !== v && wcnt < lim) begin
			@(posedge pclk);
			wcnt++;
		end
		check({31'h0, operate[u]}, {31'h0, v});
	endtask
	initial begin
		#(8 * 20000);
		n_errors++;
		final_report();
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata, block} = '0;
		{phase_v, line_v, neg_v, aux_v} = {16'd100, 16'd100, 16'd0, 16'd100};
		presetn = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1;
		rd(8'h34, 32'd300);
		rd(8'h38, 32'd50);
		rd(8'h3c, 32'd50);
		rd(8'h70, 32'hffffffff);
		rd(8'h61, 32'hffffffff);
		wr(8'h34, 32'd2000);
		rd(8'h34, 32'd1250);
		wr(8'h38, 32'hffff);
		rd(8'h38, 32'h0000ea60);
		// phase over on line voltage, instant then definite time
		wr(8'h68, 32'h1);
		wr(8'h18, 32'h0);
		wr(8'h10, 32'h1);
		line_v <= 16'd120;
		wait_op(1, 1'b1, 4);
		block <= 6'h02;
		wait_op(1, 1'b0, 3);
		block <= 6'h00;
		line_v <= 16'd100;
		wr(8'h18, 32'h2);
		line_v <= 16'd120;
		wait_op(1, 1'b1, 4 * T);
		check({31'h0, wcnt > 2 * T}, 32'h1);
		line_v <= 16'd100;
		// phase under, definite time with minimum voltage 0.2 pu
		wr(8'h68, 32'h0);
		wr(8'h08, 32'h3);
		wr(8'h00, 32'h1);
		phase_v <= 16'd50;
		wait_op(0, 1'b1, 5 * T);
		check({31'h0, wcnt > 3 * T}, 32'h1);
		phase_v <= 16'd100;
		wait_op(0, 1'b0, 2);
		// phase under on line voltage with star transformers
		wr(8'h68, 32'h2);
		line_v <= 16'd50;
		wait_op(0, 1'b1, 5 * T);
		line_v <= 16'd100;
		wait_op(0, 1'b0, 2);
		wr(8'h68, 32'h0);
		phase_v <= 16'd10;
		repeat (6 * T) @(posedge pclk);
		check({26'h0, pickup}, 32'h0);
		wr(8'h0c, 32'h0);
		wait_op(0, 1'b1, 5 * T);
		wr(8'h00, 32'h0);
		// aux under, inverse with zero delay trips at once
		wr(8'h48, 32'h0);
		wr(8'h40, 32'h3);
		aux_v <= 16'd50;
		wait_op(4, 1'b1, 4);
		aux_v <= 16'd100;
		wait_op(4, 1'b0, 2);
		// inverse at half of pickup takes twice the delay
		wr(8'h48, 32'h1);
		aux_v <= 16'd35;
		wait_op(4, 1'b1, 4 * T);
		check({31'h0, wcnt > 2 * T}, 32'h1);
		aux_v <= 16'd100;
		wait_op(4, 1'b0, 2);
		// zero sequence: three phases of 15 give 45 against 30
		wr(8'h28, 32'h0);
		wr(8'h20, 32'h1);
		phase_v <= 16'd15;
		wait_op(2, 1'b1, 4);
		phase_v <= 16'd8;
		wait_op(2, 1'b0, 4);
		// aux over, latched target cleared by status write
		wr(8'h58, 32'h0);
		wr(8'h5c, 32'h0);
		wr(8'h50, 32'h5);
		aux_v <= 16'd120;
		wait_op(5, 1'b1, 4);
		aux_v <= 16'd100;
		wait_op(5, 1'b0, 4);
		check({31'h0, target[5]}, 32'h1);
		apb(0, 8'h6c, 32'h0);
		check(r & 32'h00200000, 32'h00200000);
		wr(8'h6c, 32'h00200000);
		// clear lands on the write edge, target falls one edge later
		repeat (2) @(posedge pclk);
		check({31'h0, target[5]}, 32'h0);
		// negative sequence against saturated pickup, target disabled
		wr(8'h38, 32'h0);
		wr(8'h30, 32'h9);
		neg_v <= 16'd130;
		wait_op(3, 1'b1, 4);
		check({31'h0, target[3]}, 32'h0);
		final_report();
	end
endmodule
`default_nettype wire
